/* File: hw/fbs_map.vh */
`ifndef FBS_MAP_VH
`define FBS_MAP_VH
// ****************************************
// States (state register codes)
// ****************************************
`define FBS_ST_INIT      2'h0
`define FBS_ST_PREOP     2'h1
`define FBS_ST_SAFEOP    2'h2
`define FBS_ST_OP        2'h3
// ****************************************
// Register port offsets
// ****************************************
`define FBS_A_CTRL       4'h0
`define FBS_A_STATUS     4'h1
`define FBS_A_IN_CFG     4'h2
`define FBS_A_SAFE       4'h3
`define FBS_A_WDOG       4'h4
`define FBS_A_CYCLE      4'h5
`define FBS_A_SYNC       4'h6
`define FBS_A_DIN        4'h7
// ****************************************
// Control field positions
// ****************************************
`define FBS_C_REQ_LO     0
`define FBS_C_REQ_HI     1
`define FBS_C_REQ_STB    2
`define FBS_C_ERR        3
`define FBS_C_DCMODE     4
`define FBS_C_SAVE       5
// ****************************************
// Input config codes (2 bits per channel)
// ****************************************
`define FBS_IN_PLAIN     2'h0
`define FBS_IN_LIMIT     2'h1
`define FBS_IN_LATCH     2'h2
`define FBS_IN_BOTH      2'h3
// ****************************************
// Reset values and timing
// ****************************************
`define FBS_CLK_MHZ      50
`define FBS_WDOG_US      100
`define FBS_CYCLE_US     1000
`define FBS_SYNC_LIMIT   16'h0004
`define FBS_SYNC_MISS    16'h0003
`define FBS_INIT_CYCLES  8'h10
`endif

/* File: hw/fbs_din_sync.v */
`timescale 1ns/100ps
// ****************************************
// Three-flop input synchroniser, change once stages 2 and 3 agree
// ****************************************
module fbs_din_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         ce,
  // Data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else if (ce) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // fbs_din_sync

/* File: hw/fbs_cycle_timer.v */
`timescale 1ns/100ps
// ****************************************
// Local free-run cycle timer, one-cycle tick per period
// ****************************************
module fbs_cycle_timer #(
  parameter W = 20
) (
  // Clock and reset
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         ce,
  // Control
  input  wire         run,
  input  wire [W-1:0] period,
  output reg          tick
);
  reg [W-1:0] cnt_reg;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {W{1'b0}};
      tick    <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!run) begin
        cnt_reg <= {W{1'b0}};
      end else if (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= period) begin
        cnt_reg <= {W{1'b0}};
        tick    <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // fbs_cycle_timer

/* File: hw/fbs_slave_core.v */
// Functional notes
// - Eight travel inputs: right and left for each of four axes.
// - Each input is plain, travel limit, latch trigger, or limit and latch.
// - Four states Init, Pre-Op, Safe-Op, Op; reset enters Init.
// - Master requests state; acknowledged only after target init completes.
// - Internal error drops state to lower state without a request.
// - Init allows register access only; mailbox and process data refused.
// - Entering Init loads service data from defaults or saved values.
// - Pre-Op allows mailbox only; master sets process data channels.
// - Pre-Op offers save of motion configuration to nonvolatile storage.
// - Safe-Op: both exchanges, outputs held safe, inputs updated each cycle.
// - Free-run Op watchdog expiry drops to error Safe-Op with safe outputs; no watchdog in sync mode.
// - Fallback stops motion, sets safe current and safe digital outputs.
// - Op enables process and service data; master cycles outputs.
// - Op has free-running and clock-synchronised sub-modes.
// - Free-run cycle timed by local timer, independent of master.
// - Each cycle checks new outputs, computes path, updates outputs.
// - Then reads status and writes it to dual-port memory.
// - Sync mode: miss adds three, good subtracts one; limit enters Safe-Op.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "fbs_map.vh"
module fbs_slave_core #(
  parameter CYW         = 20,
  parameter CYCLE_TICKS = `FBS_CYCLE_US * `FBS_CLK_MHZ,
  parameter WDOG_TICKS  = `FBS_WDOG_US * `FBS_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        clk_en,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Travel inputs from pins
  input  wire [3:0]  right_travel_input,
  input  wire [3:0]  left_travel_input,
  // Slave controller side
  input  wire        out_data_new,
  input  wire [15:0] out_data,
  input  wire        sync_event,
  input  wire        sync_missed,
  input  wire        store_done,
  output reg         mbx_enable,
  output reg         pd_in_enable,
  output reg         pd_out_enable,
  output reg         status_wr,
  output reg  [15:0] status_data,
  output reg         load_defaults,
  output reg         load_saved,
  output reg         store_req,
  // Motion engine side
  input  wire [15:0] motion_status,
  output reg         motion_wr,
  output reg  [15:0] motion_cmd,
  output reg         motion_stop,
  output reg  [7:0]  motor_current,
  output reg  [1:0]  dout,
  output reg  [3:0]  pos_limit,
  output reg  [3:0]  neg_limit,
  output reg  [7:0]  latch_trig
);
  localparam CS_IDLE = 2'h0;
  localparam CS_MOVE = 2'h1;
  localparam CS_READ = 2'h2;
  localparam CS_POST = 2'h3;

  // ****************************************
  // Registers
  // ****************************************
  reg [1:0]      state_reg;
  reg [1:0]      target_reg;
  reg            pending_reg;
  reg [7:0]      init_cnt_reg;
  reg            wd_fault_reg;
  reg            sync_err_reg;
  reg            use_saved_reg;
  reg            dc_mode_reg;
  reg [15:0]     in_cfg_reg;
  reg [9:0]      safe_reg;
  reg [CYW-1:0]  wdog_reg;
  reg [CYW-1:0]  period_reg;
  reg [15:0]     sync_lim_reg;
  reg [15:0]     sync_cnt_reg;
  reg [CYW-1:0]  wd_cnt_reg;
  reg [1:0]      cs_reg;
  reg [15:0]     latched_out_reg;
  reg [7:0]      din_edge_reg;
  reg            new_pend_reg;
  wire [7:0]     din_s;
  wire           tick;
  wire           cycle_go;
  wire           new_avail;

  // ****************************************
  // Input sync and cycle timer
  // ****************************************
  fbs_din_sync #(.W(8)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (clk_en),
    .din     ({left_travel_input, right_travel_input}),
    .dout    (din_s)
  );

  fbs_cycle_timer #(.W(CYW)) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (clk_en),
    .run     (state_reg == `FBS_ST_SAFEOP || state_reg == `FBS_ST_OP),
    .period  (period_reg),
    .tick    (tick)
  );

  function is_lower;
    input [1:0] a;
    input [1:0] b;
    begin
      is_lower = (a < b);
    end
  endfunction

  wire       op_run    = (state_reg == `FBS_ST_OP) && !wd_fault_reg;
  wire       wd_expire = op_run && !dc_mode_reg && (wd_cnt_reg >= wdog_reg);
  wire [16:0] sync_sum = {1'b0, sync_cnt_reg} + {1'b0, `FBS_SYNC_MISS};
  wire       sync_trip = op_run && dc_mode_reg && sync_event && sync_missed
                         && (sync_sum[15:0] >= sync_lim_reg);
  // Cycle start: local tick in free run, sync event in dc mode
  assign cycle_go  = (cs_reg == CS_IDLE)
                     && (tick && !dc_mode_reg || sync_event && dc_mode_reg && state_reg[1]);
  assign new_avail = new_pend_reg || out_data_new;

  // ****************************************
  // State machine
  // ****************************************
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg     <= `FBS_ST_INIT;
      target_reg    <= `FBS_ST_INIT;
      pending_reg   <= 1'b0;
      init_cnt_reg  <= 8'h00;
      wd_fault_reg  <= 1'b0;
      sync_err_reg  <= 1'b0;
      load_defaults <= 1'b1;
      load_saved    <= 1'b0;
      wd_cnt_reg    <= {CYW{1'b0}};
      sync_cnt_reg  <= 16'h0000;
    end else if (clk_en) begin
      load_defaults <= 1'b0;
      load_saved    <= 1'b0;
      // Watchdog counts cycles without fresh outputs
      if (out_data_new || state_reg != `FBS_ST_OP) begin
        wd_cnt_reg <= {CYW{1'b0}};
      end else if (wd_cnt_reg < wdog_reg) begin
        wd_cnt_reg <= wd_cnt_reg + {{(CYW-1){1'b0}}, 1'b1};
      end
      if (op_run && dc_mode_reg && sync_event) begin
        if (sync_missed) begin
          sync_cnt_reg <= sync_sum[15:0];
        end else if (sync_cnt_reg != 16'h0000) begin
          sync_cnt_reg <= sync_cnt_reg - 16'h0001;
        end
      end
      // Error and faults override pending requests
      if (reg_wr && reg_addr == `FBS_A_CTRL && reg_wdata[`FBS_C_ERR]) begin
        state_reg   <= is_lower(state_reg, `FBS_ST_PREOP) ? state_reg : `FBS_ST_PREOP;
        pending_reg <= 1'b0;
      end else if (wd_expire || sync_trip) begin
        state_reg    <= `FBS_ST_SAFEOP;
        wd_fault_reg <= wd_expire;
        sync_err_reg <= sync_trip;
        pending_reg  <= 1'b0;
      end else if (reg_wr && reg_addr == `FBS_A_CTRL && reg_wdata[`FBS_C_REQ_STB]) begin
        target_reg   <= reg_wdata[`FBS_C_REQ_HI:`FBS_C_REQ_LO];
        pending_reg  <= 1'b1;
        init_cnt_reg <= `FBS_INIT_CYCLES;
      end else if (pending_reg) begin
        if (init_cnt_reg != 8'h00) begin
          init_cnt_reg <= init_cnt_reg - 8'h01;
        end else begin
          state_reg   <= target_reg;
          pending_reg <= 1'b0;
          if (target_reg == `FBS_ST_INIT) begin
            load_defaults <= !use_saved_reg;
            load_saved    <= use_saved_reg;
          end
          if (target_reg == `FBS_ST_OP) begin
            wd_fault_reg <= 1'b0;
            sync_err_reg <= 1'b0;
            sync_cnt_reg <= 16'h0000;
          end
        end
      end
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dc_mode_reg   <= 1'b0;
      use_saved_reg <= 1'b0;
      store_req     <= 1'b0;
      in_cfg_reg    <= 16'h0000;
      safe_reg      <= 10'h000;
      wdog_reg      <= WDOG_TICKS[CYW-1:0];
      period_reg    <= CYCLE_TICKS[CYW-1:0];
      sync_lim_reg  <= `FBS_SYNC_LIMIT;
      reg_rdata     <= 32'h0000_0000;
    end else if (clk_en) begin
      if (store_done) begin
        store_req     <= 1'b0;
        use_saved_reg <= 1'b1;
      end
      if (reg_wr) begin
        case (reg_addr)
          `FBS_A_CTRL: begin
            dc_mode_reg <= reg_wdata[`FBS_C_DCMODE];
            if (reg_wdata[`FBS_C_SAVE] && state_reg == `FBS_ST_PREOP) begin
              store_req <= 1'b1;
            end
          end
          `FBS_A_IN_CFG: in_cfg_reg <= reg_wdata[15:0];
          `FBS_A_SAFE: safe_reg <= reg_wdata[9:0];
          `FBS_A_WDOG: wdog_reg <= reg_wdata[CYW-1:0];
          `FBS_A_CYCLE: period_reg <= reg_wdata[CYW-1:0];
          `FBS_A_SYNC: sync_lim_reg <= reg_wdata[15:0];
          default: ;
        endcase
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `FBS_A_CTRL: reg_rdata <= {26'h0, store_req, dc_mode_reg, 4'h0};
          `FBS_A_STATUS: reg_rdata <= {24'h0, use_saved_reg, sync_err_reg,
                                       wd_fault_reg, pending_reg, target_reg, state_reg};
          `FBS_A_IN_CFG: reg_rdata <= {16'h0, in_cfg_reg};
          `FBS_A_SAFE: reg_rdata <= {22'h0, safe_reg};
          `FBS_A_WDOG: reg_rdata <= {{(32-CYW){1'b0}}, wdog_reg};
          `FBS_A_CYCLE: reg_rdata <= {{(32-CYW){1'b0}}, period_reg};
          `FBS_A_SYNC: reg_rdata <= {sync_cnt_reg, sync_lim_reg};
          `FBS_A_DIN: reg_rdata <= {24'h0, din_s};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // New output data flag
  // ****************************************
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      new_pend_reg <= 1'b0;
    end else if (clk_en) begin
      if (cycle_go) begin
        // A pulse in the same cycle is consumed right away
        new_pend_reg <= 1'b0;
      end else if (out_data_new) begin
        new_pend_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Cycle sequence and outputs
  // ****************************************
  integer k;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cs_reg          <= CS_IDLE;
      latched_out_reg <= 16'h0000;
      din_edge_reg    <= 8'h00;
      mbx_enable      <= 1'b0;
      pd_in_enable    <= 1'b0;
      pd_out_enable   <= 1'b0;
      status_wr       <= 1'b0;
      status_data     <= 16'h0000;
      motion_wr       <= 1'b0;
      motion_cmd      <= 16'h0000;
      motion_stop     <= 1'b1;
      motor_current   <= 8'h00;
      dout            <= 2'h0;
      pos_limit       <= 4'h0;
      neg_limit       <= 4'h0;
      latch_trig      <= 8'h00;
    end else if (clk_en) begin
      mbx_enable    <= state_reg != `FBS_ST_INIT;
      pd_in_enable  <= state_reg[1];
      pd_out_enable <= op_run;
      status_wr     <= 1'b0;
      motion_wr     <= 1'b0;
      din_edge_reg  <= din_s;
      for (k = 0; k < 4; k = k + 1) begin
        pos_limit[k] <= in_cfg_reg[2*k] & din_s[k];
        neg_limit[k] <= in_cfg_reg[2*k+8] & din_s[k+4];
      end
      for (k = 0; k < 8; k = k + 1) begin
        latch_trig[k] <= in_cfg_reg[2*k+1] & din_s[k] & !din_edge_reg[k];
      end
      if (!op_run) begin
        motion_stop   <= 1'b1;
        motor_current <= safe_reg[7:0];
        dout          <= safe_reg[9:8];
      end
      case (cs_reg)
        CS_IDLE: begin
          if (cycle_go) begin
            if (op_run && new_avail) begin
              latched_out_reg <= out_data;
              cs_reg          <= CS_MOVE;
            end else begin
              cs_reg <= CS_READ;
            end
          end
        end
        CS_MOVE: begin
          if (op_run) begin
            motion_cmd  <= latched_out_reg;
            motion_wr   <= 1'b1;
            motion_stop <= 1'b0;
            dout        <= latched_out_reg[1:0];
          end
          cs_reg <= CS_READ;
        end
        CS_READ: begin
          status_data <= {motion_status[15:8], din_s};
          cs_reg      <= CS_POST;
        end
        CS_POST: begin
          status_wr <= 1'b1;
          cs_reg    <= CS_IDLE;
        end
        default: cs_reg <= CS_IDLE;
      endcase
    end
  end
endmodule // fbs_slave_core

/* File: dv/fbs_slave_props.sv */
`timescale 1ns/100ps
// ****
// Port checker for the slave core
// ****
module fbs_slave_props (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Watched ports
  input wire [15:0] out_data,
  input wire [15:0] motion_status,
  input wire        mbx_enable,
  input wire        pd_in_enable,
  input wire        pd_out_enable,
  input wire        status_wr,
  input wire [15:0] status_data,
  input wire        load_defaults,
  input wire        load_saved,
  input wire        store_req,
  input wire        motion_wr,
  input wire        motion_stop,
  input wire [1:0]  dout
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_INIT_NO_PD: assert property (!mbx_enable |-> !pd_in_enable && !pd_out_enable)
    else $error("process data open without mailbox");
  AST_PD_NEEDS_MBX: assert property (pd_in_enable |-> mbx_enable)
    else $error("input data open without mailbox");
  AST_OP_BOTH: assert property (pd_out_enable |-> pd_in_enable)
    else $error("output data open without input data");
  AST_MOVE_IN_OP: assert property (motion_wr |-> pd_out_enable)
    else $error("motion written outside op");
  AST_MOVE_DOUT: assert property (motion_wr |-> dout == $past(out_data[1:0], 2))
    else $error("digital outputs not from output data");
  AST_STATUS_AFTER: assert property (motion_wr |-> !status_wr ##2 status_wr)
    else $error("status not written two cycles after motion");
  AST_STATUS_DATA: assert property (status_wr |->
    status_data[15:8] == $past(motion_status[15:8], 2))
    else $error("status data not from motion engine");
  AST_FALLBACK_STOP: assert property ($fell(pd_out_enable) |-> ##[0:2] motion_stop)
    else $error("motion not stopped on leaving op");
  AST_INIT_LOAD: assert property ($fell(mbx_enable) |-> $past(load_defaults) || $past(load_saved))
    else $error("no service data load on entering init");
  AST_SAVE_PREOP: assert property ($rose(store_req) |-> mbx_enable && !pd_in_enable)
    else $error("save started outside pre-op");
  cover property (motion_wr ##2 status_wr);
  cover property ($fell(pd_out_enable) && pd_in_enable);
  cover property ($rose(store_req) ##[1:20] !store_req);
endmodule // fbs_slave_props

bind fbs_slave_core fbs_slave_props u_props (
  .ref_clk(ref_clk), .rst(rst), .out_data(out_data), .motion_status(motion_status),
  .mbx_enable(mbx_enable), .pd_in_enable(pd_in_enable), .pd_out_enable(pd_out_enable),
  .status_wr(status_wr), .status_data(status_data), .load_defaults(load_defaults),
  .load_saved(load_saved), .store_req(store_req), .motion_wr(motion_wr),
  .motion_stop(motion_stop), .dout(dout)
);

/* File: dv/fbs_ctl_model.sv */
`timescale 1ns/100ps
// ****
// Slave controller and master stand-in
// ****
module fbs_ctl_model #(
  parameter GAP = 50
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Bench control
  input  wire        stream_en,
  input  wire [15:0] out_val,
  input  wire        sync_go,
  input  wire        sync_bad,
  // Block side
  input  wire        store_req,
  output reg         out_data_new,
  output reg  [15:0] out_data,
  output reg         sync_event,
  output reg         sync_missed,
  output reg         store_done
);
  localparam [7:0] LAST = GAP - 1;
  reg [7:0] gap_cnt;
  reg [3:0] nv_cnt;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_cnt      <= 8'h00;
      nv_cnt       <= 4'h0;
      out_data_new <= 1'b0;
      out_data     <= 16'h0000;
      sync_event   <= 1'b0;
      sync_missed  <= 1'b0;
      store_done   <= 1'b0;
    end else begin
      // Fresh outputs once per bus cycle
      out_data_new <= stream_en && gap_cnt == LAST;
      gap_cnt      <= (gap_cnt == LAST) ? 8'h00 : gap_cnt + 8'h01;
      if (stream_en && gap_cnt == LAST) begin
        out_data <= out_val;
      end
      sync_event  <= sync_go;
      sync_missed <= sync_go ? sync_bad : ~sync_missed;
      nv_cnt      <= (store_req && !store_done) ? nv_cnt + 4'h1 : 4'h0;
      store_done  <= store_req && nv_cnt == 4'h7;
    end
  end
endmodule // fbs_ctl_model

/* File: dv/tb.sv */
`timescale 1ns/100ps
`include "fbs_map.vh"
`define CHK(n, g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
`define WAITC(c, n) begin for (k = 0; k < n && !(c); k++) @(negedge ref_clk); \
  if (!(c)) begin errors++; tally_and_finish(); end end
module tb;
  // ****
  // Stimulus and wiring
  // ****
  reg         ref_clk   = 1'b0;
  reg         rst       = 1'b1;
  reg  [3:0]  reg_addr  = 4'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr    = 1'b0;
  reg         reg_rd    = 1'b0;
  reg  [3:0]  right_in  = 4'h0;
  reg  [3:0]  left_in   = 4'h0;
  reg         stream_en = 1'b0;
  reg  [15:0] out_val   = 16'h0002;
  reg         sync_go   = 1'b0;
  reg         sync_bad  = 1'b0;
  reg         dc        = 1'b0;
  integer     errors    = 0;
  integer     check_count = 0;
  integer     k;
  wire [31:0] reg_rdata;
  wire [15:0] out_data, status_data, motion_cmd;
  wire [7:0]  motor_current, latch_trig;
  wire [3:0]  pos_limit, neg_limit;
  wire [1:0]  dout;
  wire        odn, sev, smiss, sdone, store_req, mbx_enable, pd_in_enable, pd_out_enable;
  wire        status_wr, motion_wr, motion_stop, load_def, load_sav;
  integer     def_loads = 0;
  integer     sav_loads = 0;
  always #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    def_loads <= def_loads + (load_def && !rst);
    sav_loads <= sav_loads + load_sav;
  end
  fbs_slave_core #(.CYCLE_TICKS(40), .WDOG_TICKS(200)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .right_travel_input(right_in),
    .left_travel_input(left_in), .out_data_new(odn), .out_data(out_data), .sync_event(sev),
    .sync_missed(smiss), .store_done(sdone), .mbx_enable(mbx_enable),
    .pd_in_enable(pd_in_enable), .pd_out_enable(pd_out_enable), .status_wr(status_wr),
    .status_data(status_data), .load_defaults(load_def), .load_saved(load_sav),
    .store_req(store_req), .motion_status(16'hc300), .motion_wr(motion_wr),
    .motion_cmd(motion_cmd), .motion_stop(motion_stop),
    .motor_current(motor_current), .dout(dout), .pos_limit(pos_limit),
    .neg_limit(neg_limit), .latch_trig(latch_trig));
  fbs_ctl_model u_ctl (
    .ref_clk(ref_clk), .rst(rst), .stream_en(stream_en), .out_val(out_val),
    .sync_go(sync_go), .sync_bad(sync_bad), .store_req(store_req), .out_data_new(odn),
    .out_data(out_data), .sync_event(sev), .sync_missed(smiss), .store_done(sdone));
  task automatic wr(input [3:0] a, input [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [3:0] a, output [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic go(input [1:0] st);
    reg [31:0] d;
    wr(`FBS_A_CTRL, {27'h0, dc, 2'h1, st});
    repeat (6) @(negedge ref_clk);
    rd(`FBS_A_STATUS, d);
    `CHK("pending", {d[4], d[3:2]}, {1'b1, st})
    repeat (14) @(negedge ref_clk);
    rd(`FBS_A_STATUS, d);
    `CHK("state", d[1:0], st)
  endtask
  task automatic sync_pulse(input b);
    @(posedge ref_clk);
    sync_go  <= 1'b1;
    sync_bad <= b;
    @(posedge ref_clk);
    sync_go <= 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic t_reset_inputs;
    reg [31:0] d;
    rd(`FBS_A_STATUS, d);
    `CHK("reset state", d[1:0], `FBS_ST_INIT)
    `CHK("init exch", {mbx_enable, pd_in_enable, pd_out_enable, motion_stop}, 4'h1)
    rd(4'hf, d);
    `CHK("unmapped", d, 32'h0)
    rd(`FBS_A_WDOG, d);
    `CHK("wdog reset", d, 32'hc8)
    rd(`FBS_A_CYCLE, d);
    `CHK("cycle reset", d, 32'h28)
    wr(`FBS_A_IN_CFG, 32'haa55);
    @(posedge ref_clk);
    right_in <= 4'ha;
    left_in  <= 4'h5;
    `WAITC(latch_trig != 8'h0, 12)
    `CHK("latch", latch_trig, 8'h50)
    repeat (3) @(negedge ref_clk);
    `CHK("limits", {neg_limit, pos_limit}, 8'h0a)
    rd(`FBS_A_DIN, d);
    `CHK("din", d[7:0], 8'h5a)
    $display("test reset_inputs done");
  endtask
  task automatic t_preop_safeop;
    integer mw;
    integer sw;
    go(`FBS_ST_PREOP);
    `CHK("preop exch", {mbx_enable, pd_in_enable}, 2'h2)
    wr(`FBS_A_CTRL, 32'h20);
    `WAITC(store_req, 4)
    `WAITC(!store_req, 40)
    `CHK("save done", store_req, 1'b0)
    @(posedge ref_clk);
    stream_en <= 1'b1;
    go(`FBS_ST_SAFEOP);
    mw = 0;
    sw = 0;
    repeat (120) begin
      @(negedge ref_clk);
      mw += motion_wr;
      sw += status_wr;
    end
    `CHK("safeop outs", {pd_in_enable, pd_out_enable, motion_stop, mw == 0}, 4'hb)
    `CHK("safeop inputs", sw >= 2, 1'b1)
    $display("test preop_safeop done");
  endtask
  task automatic t_op_error;
    reg [31:0] d;
    wr(`FBS_A_SAFE, 32'h1a5);
    go(`FBS_ST_OP);
    `WAITC(motion_wr, 200)
    `CHK("move dout", dout, out_val[1:0])
    `CHK("move cmd", motion_cmd, out_val)
    `WAITC(status_wr, 6)
    `CHK("status", status_data[15:8], 8'hc3)
    `WAITC(motion_wr, 200)
    wr(`FBS_A_CTRL, 32'h8);
    repeat (4) @(negedge ref_clk);
    rd(`FBS_A_STATUS, d);
    `CHK("error drop", {d[1:0], pd_out_enable}, {`FBS_ST_PREOP, 1'b0})
    $display("test op_error done");
  endtask
  task automatic t_wdog;
    reg [31:0] d;
    go(`FBS_ST_SAFEOP);
    go(`FBS_ST_OP);
    @(posedge ref_clk);
    stream_en <= 1'b0;
    `WAITC(!pd_out_enable, 400)
    `CHK("wd time", k >= 140, 1'b1)
    rd(`FBS_A_STATUS, d);
    `CHK("wd state", {d[5], d[1:0]}, {1'b1, `FBS_ST_SAFEOP})
    `CHK("wd safe", {motion_stop, motor_current, dout}, {1'b1, 8'ha5, 2'h1})
    @(posedge ref_clk);
    stream_en <= 1'b1;
    repeat (150) @(negedge ref_clk);
    `CHK("wd hold", {pd_out_enable, dout}, 3'h1)
    go(`FBS_ST_OP);
    `CHK("wd return", pd_out_enable, 1'b1)
    $display("test wdog done");
  endtask
  task automatic t_sync_init;
    reg [31:0] d;
    dc = 1'b1;
    wr(`FBS_A_CTRL, 32'h10);
    sync_pulse(1'b1);
    rd(`FBS_A_SYNC, d);
    `CHK("sync miss", {d, pd_out_enable}, {32'h00030004, 1'b1})
    sync_pulse(1'b0);
    rd(`FBS_A_SYNC, d);
    `CHK("sync good", d, 32'h00020004)
    sync_pulse(1'b1);
    rd(`FBS_A_STATUS, d);
    `CHK("sync trip", {d[6], d[1:0]}, {1'b1, `FBS_ST_SAFEOP})
    go(`FBS_ST_INIT);
    `CHK("back init", mbx_enable, 1'b0)
    `CHK("init loads", {def_loads[3:0], sav_loads[3:0]}, 8'h11)
    $display("test sync_init done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset_inputs;
    t_preop_safeop;
    t_op_error;
    t_wdog;
    t_sync_init;
    tally_and_finish;
  end
endmodule // tb
